// ==== logic/cpr_pkg.sv ====
// constants for the channel playback parameter register bank
package cpr_pkg;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned ADDR_W      = 16;
    localparam int unsigned LOC_W       = 12;
    localparam int unsigned LOC_LSB     = 4;
    localparam int unsigned RSV_W       = 4;
    localparam int unsigned NUM_CH      = 3;
    localparam int unsigned REGS_PER_CH = 4;
    // channel 4 block base; channels 3 and 2 follow at steps of four
    localparam logic [15:0] OFF_CH4_LAUNCH_DELAY = 16'h0050;
    localparam logic [15:0] OFF_CH4_FETCH_FIRST  = 16'h0051;
    localparam logic [15:0] OFF_CH4_FETCH_LAST   = 16'h0052;
    localparam logic [15:0] OFF_CH4_SINE_COUNT   = 16'h0053;
    localparam logic [15:0] OFF_CH3_LAUNCH_DELAY = 16'h0054;
    localparam logic [15:0] OFF_CH3_FETCH_FIRST  = 16'h0055;
    localparam logic [15:0] OFF_CH3_FETCH_LAST   = 16'h0056;
    localparam logic [15:0] OFF_CH3_SINE_COUNT   = 16'h0057;
    localparam logic [15:0] OFF_CH2_LAUNCH_DELAY = 16'h0058;
    localparam logic [15:0] OFF_CH2_FETCH_FIRST  = 16'h0059;
    localparam logic [15:0] OFF_CH2_FETCH_LAST   = 16'h005a;
    localparam logic [15:0] OFF_CH2_SINE_COUNT   = 16'h005b;
    localparam logic [15:0] OFF_BANK_BASE        = OFF_CH4_LAUNCH_DELAY;
    localparam logic [15:0] OFF_BANK_END         = OFF_CH2_SINE_COUNT;
    // register kinds within a channel block, in address order
    localparam logic [1:0]  KIND_LAUNCH = 2'h0;
    localparam logic [1:0]  KIND_FIRST  = 2'h1;
    localparam logic [1:0]  KIND_LAST   = 2'h2;
    localparam logic [1:0]  KIND_SINE   = 2'h3;
    localparam logic [15:0] RST_LAUNCH_DELAY = 16'h0000;
    localparam logic [11:0] RST_LOCATION     = 12'h000;
    localparam logic [3:0]  RST_RESERVED     = 4'h0;
    localparam logic [15:0] RST_SINE_COUNT   = 16'h0001;
    localparam logic [15:0] UNMAPPED_READ    = 16'h0000;
endpackage

// ==== logic/cpr_channel.sv ====
// one channel's four playback parameter registers
`timescale 1ns/1ps
module cpr_channel
    import cpr_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    input  wire logic                 sel,
    input  wire logic                 wr_stb,
    input  wire logic [1:0]           kind,
    input  wire logic [DATA_W-1:0]    wr_data,
    output logic      [DATA_W-1:0]    launch_offset,
    output logic      [LOC_W-1:0]     first_location,
    output logic      [LOC_W-1:0]     last_location,
    output logic      [DATA_W-1:0]    sine_repeat,
    output logic      [DATA_W-1:0]    rd_word
);
    logic wr_en;
    assign wr_en = sel && wr_stb;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            launch_offset <= RST_LAUNCH_DELAY;
        end else if (wr_en && kind == KIND_LAUNCH) begin
            launch_offset <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            first_location <= RST_LOCATION;
        end else if (wr_en && kind == KIND_FIRST) begin
            first_location <= wr_data[DATA_W-1:LOC_LSB];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_location <= RST_LOCATION;
        end else if (wr_en && kind == KIND_LAST) begin
            last_location <= wr_data[DATA_W-1:LOC_LSB];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sine_repeat <= RST_SINE_COUNT;
        end else if (wr_en && kind == KIND_SINE) begin
            sine_repeat <= wr_data;
        end
    end

    // low nibble of address registers is not stored, so it always reads zero
    always_comb begin
        unique case (kind)
            KIND_LAUNCH: rd_word = launch_offset;
            KIND_FIRST:  rd_word = {first_location, RST_RESERVED};
            KIND_LAST:   rd_word = {last_location, RST_RESERVED};
            KIND_SINE:   rd_word = sine_repeat;
        endcase
    end
endmodule // cpr_channel

// ==== logic/cpr_bank.sv ====
// playback parameter register bank for channels 4, 3 and 2
`timescale 1ns/1ps
module cpr_bank
    import cpr_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    input  wire logic [cpr_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [cpr_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [cpr_pkg::DATA_W-1:0] reg_rdata,
    output logic      [cpr_pkg::DATA_W-1:0] ch4_launch_offset,
    output logic      [cpr_pkg::LOC_W-1:0]  ch4_first_location,
    output logic      [cpr_pkg::LOC_W-1:0]  ch4_last_location,
    output logic      [cpr_pkg::DATA_W-1:0] ch4_sine_repeat,
    output logic      [cpr_pkg::DATA_W-1:0] ch3_launch_offset,
    output logic      [cpr_pkg::LOC_W-1:0]  ch3_first_location,
    output logic      [cpr_pkg::LOC_W-1:0]  ch3_last_location,
    output logic      [cpr_pkg::DATA_W-1:0] ch3_sine_repeat,
    output logic      [cpr_pkg::DATA_W-1:0] ch2_launch_offset,
    output logic      [cpr_pkg::LOC_W-1:0]  ch2_first_location,
    output logic      [cpr_pkg::LOC_W-1:0]  ch2_last_location,
    output logic      [cpr_pkg::DATA_W-1:0] ch2_sine_repeat,
    output logic                       range_inverted
);
    import cpr_pkg::*;

    // channel index 0 is channel 4, 1 is channel 3, 2 is channel 2
    logic [DATA_W-1:0] launch_q [NUM_CH];
    logic [LOC_W-1:0]  first_q  [NUM_CH];
    logic [LOC_W-1:0]  last_q   [NUM_CH];
    logic [DATA_W-1:0] sine_q   [NUM_CH];
    logic [DATA_W-1:0] word_q   [NUM_CH];
    logic [NUM_CH-1:0] ch_sel;
    logic [NUM_CH-1:0] inv_each;
    logic              in_bank;
    logic [15:0]       rel;
    logic [1:0]        kind;
    logic [DATA_W-1:0] next_rdata;
    logic              next_inverted;

    assign in_bank = (reg_addr >= OFF_BANK_BASE) && (reg_addr <= OFF_BANK_END);
    assign rel     = reg_addr - OFF_BANK_BASE;
    assign kind    = rel[1:0];

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        assign ch_sel[c]   = in_bank && (rel[3:2] == 2'(c));
        assign inv_each[c] = first_q[c] > last_q[c];
        cpr_channel u_ch (
            .core_clk       (core_clk),
            .reset_n        (reset_n),
            .sel            (ch_sel[c]),
            .wr_stb         (reg_wr),
            .kind           (kind),
            .wr_data        (reg_wdata),
            .launch_offset  (launch_q[c]),
            .first_location (first_q[c]),
            .last_location  (last_q[c]),
            .sine_repeat    (sine_q[c]),
            .rd_word        (word_q[c])
        );
    end

    always_comb begin
        next_rdata = UNMAPPED_READ;
        for (int c = 0; c < NUM_CH; c++) begin
            if (ch_sel[c]) begin
                next_rdata = word_q[c];
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= UNMAPPED_READ;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= UNMAPPED_READ;
        end
    end

    // flag only; a bad range is still passed to the pattern engine unchanged
    assign next_inverted = |inv_each;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            range_inverted <= 1'b0;
        end else begin
            range_inverted <= next_inverted;
        end
    end

    // registered copies keep every output straight from a flip-flop
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ch4_launch_offset <= RST_LAUNCH_DELAY;
            ch3_launch_offset <= RST_LAUNCH_DELAY;
            ch2_launch_offset <= RST_LAUNCH_DELAY;
        end else begin
            ch4_launch_offset <= launch_q[0];
            ch3_launch_offset <= launch_q[1];
            ch2_launch_offset <= launch_q[2];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ch4_first_location <= RST_LOCATION;
            ch3_first_location <= RST_LOCATION;
            ch2_first_location <= RST_LOCATION;
            ch4_last_location  <= RST_LOCATION;
            ch3_last_location  <= RST_LOCATION;
            ch2_last_location  <= RST_LOCATION;
        end else begin
            ch4_first_location <= first_q[0];
            ch3_first_location <= first_q[1];
            ch2_first_location <= first_q[2];
            ch4_last_location  <= last_q[0];
            ch3_last_location  <= last_q[1];
            ch2_last_location  <= last_q[2];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ch4_sine_repeat <= RST_SINE_COUNT;
            ch3_sine_repeat <= RST_SINE_COUNT;
            ch2_sine_repeat <= RST_SINE_COUNT;
        end else begin
            ch4_sine_repeat <= sine_q[0];
            ch3_sine_repeat <= sine_q[1];
            ch2_sine_repeat <= sine_q[2];
        end
    end
endmodule // cpr_bank

// ==== dv/cpr_bank_monitor.sv ====
// assertion checker for the playback parameter register bank
`timescale 1ns/1ps
module cpr_bank_monitor
    import cpr_pkg::*;
(
    input wire logic                        core_clk,
    input wire logic                        reset_n,
    input wire logic [cpr_pkg::ADDR_W-1:0]  reg_addr,
    input wire logic [cpr_pkg::DATA_W-1:0]  reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [cpr_pkg::DATA_W-1:0]  reg_rdata,
    input wire logic [cpr_pkg::DATA_W-1:0]  ch4_launch_offset,
    input wire logic [cpr_pkg::LOC_W-1:0]   ch4_first_location,
    input wire logic [cpr_pkg::LOC_W-1:0]   ch4_last_location,
    input wire logic [cpr_pkg::DATA_W-1:0]  ch2_sine_repeat,
    input wire logic                        range_inverted
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence rd_first;
        reg_rd && reg_addr == OFF_CH4_FETCH_FIRST;
    endsequence
    sequence wr_first;
        reg_wr && reg_addr == OFF_CH4_FETCH_FIRST;
    endsequence
    a_launch_store: assert property (
        reg_wr && reg_addr == OFF_CH4_LAUNCH_DELAY |-> ##2 ch4_launch_offset == $past(reg_wdata, 2))
        else $error("start delay output wrong after write");
    a_first_store: assert property (
        wr_first |-> ##2 ch4_first_location == $past(reg_wdata[15:4], 2))
        else $error("start location output wrong after write");
    a_first_readback: assert property (
        rd_first |=> reg_rdata == {ch4_first_location, 4'h0})
        else $error("start location read disagrees with output");
    a_reserved_zero: assert property (
        reg_rd && reg_addr inside {16'h0051, 16'h0052, 16'h0055, 16'h0056, 16'h0059, 16'h005a}
        |=> reg_rdata[3:0] == 4'h0)
        else $error("reserved bits read nonzero");
    a_sine_reset: assert property (
        $rose(reset_n) |-> ch2_sine_repeat == RST_SINE_COUNT)
        else $error("sine count not one after reset");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (
        reg_rd && (reg_addr < OFF_BANK_BASE || reg_addr > OFF_BANK_END) |=> reg_rdata == 16'h0000)
        else $error("unmapped read nonzero");
    a_range_flag: assert property (
        (ch4_first_location > ch4_last_location) [*3] |-> range_inverted)
        else $error("inverted range not flagged");
endmodule // cpr_bank_monitor

bind cpr_bank cpr_bank_monitor u_mon (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ch4_launch_offset, .ch4_first_location, .ch4_last_location,
    .ch2_sine_repeat, .range_inverted);

// ==== dv/cpr_testbench.sv ====
// self-checking bench for the playback parameter register bank
`timescale 1ns/1ps
module testbench;
    import cpr_pkg::*;
    logic        core_clk, reset_n, reg_wr, reg_rd, range_inverted;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, ch4_launch_offset, ch4_sine_repeat;
    logic [15:0] ch3_launch_offset, ch3_sine_repeat, ch2_launch_offset, ch2_sine_repeat;
    logic [11:0] ch4_first_location, ch4_last_location, ch3_first_location;
    logic [11:0] ch3_last_location, ch2_first_location, ch2_last_location;
    int          miscompares = 0, total_checks = 0, cycles = 0;
    // outputs regrouped in register order, reserved nibble shown as zero
    function automatic logic [15:0] obs(int i);
        case (i)
            0:       return ch4_launch_offset;
            1:       return {ch4_first_location, 4'h0};
            2:       return {ch4_last_location, 4'h0};
            3:       return ch4_sine_repeat;
            4:       return ch3_launch_offset;
            5:       return {ch3_first_location, 4'h0};
            6:       return {ch3_last_location, 4'h0};
            7:       return ch3_sine_repeat;
            8:       return ch2_launch_offset;
            9:       return {ch2_first_location, 4'h0};
            10:      return {ch2_last_location, 4'h0};
            default: return ch2_sine_repeat;
        endcase
    endfunction
    cpr_bank u_dut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .ch4_launch_offset, .ch4_first_location, .ch4_last_location, .ch4_sine_repeat,
        .ch3_launch_offset, .ch3_first_location, .ch3_last_location, .ch3_sine_repeat,
        .ch2_launch_offset, .ch2_first_location, .ch2_last_location, .ch2_sine_repeat,
        .range_inverted);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
    endtask
    // write strobe stays up so writes run back to back; idle lowers it
    task automatic wr(logic [15:0] a, logic [15:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic idle();
        @(posedge core_clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic rd(logic [15:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    function automatic logic [15:0] pat(int i);
        return 16'(16'h1357 * (i + 1));
    endfunction
    function automatic logic [15:0] keep(int i, logic [15:0] d);
        return (i % 4 == 1 || i % 4 == 2) ? (d & 16'hfff0) : d;
    endfunction
    task automatic t_sweep(bit written);
        logic [15:0] d, e;
        for (int i = 0; i < 12; i++) begin
            e = written ? keep(i, pat(i)) : ((i % 4 == 3) ? 16'h0001 : 16'h0000);
            rd(OFF_BANK_BASE + 16'(i), d);
            chk("register read", d, e);
            chk("parameter output", obs(i), e);
        end
        chk("range flag", {15'h0, range_inverted}, 16'h0000);
        $display("sweep test done");
    endtask
    task automatic t_unmapped();
        logic [15:0] d;
        wr(16'h004f, 16'hffff);
        wr(16'h005c, 16'hffff);
        idle();
        rd(16'h004f, d);
        chk("unmapped below", d, 16'h0000);
        rd(16'h005c, d);
        chk("unmapped above", d, 16'h0000);
        rd(16'hffff, d);
        chk("unmapped top", d, 16'h0000);
        rd(OFF_CH4_LAUNCH_DELAY, d);
        chk("neighbour kept", d, pat(0));
        chk("upper neighbour kept", obs(11), pat(11));
        $display("unmapped test done");
    endtask
    task automatic t_inverted();
        wr(OFF_CH4_FETCH_FIRST, 16'h5560);
        wr(OFF_CH4_FETCH_LAST, 16'h555f);
        idle();
        chk("range flag set", {15'h0, range_inverted}, 16'h0001);
        wr(OFF_CH4_FETCH_LAST, 16'h5567);
        idle();
        chk("range flag equal", {15'h0, range_inverted}, 16'h0000);
        $display("range test done");
    endtask
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        do_reset();
        t_sweep(1'b0);
        for (int i = 0; i < 12; i++) wr(OFF_BANK_BASE + 16'(i), pat(i));
        idle();
        t_sweep(1'b1);
        t_unmapped();
        t_inverted();
        do_reset();
        t_sweep(1'b0);
        end_sim();
    end
endmodule // testbench
